// File: scu_pkg.sv
// Package with register map, field positions and timing constants of the card UART status block.
package scu_pkg;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_ETU_DIVIDER = 6'h02;
    localparam logic [5:0] IDX_UART_CONFIG_TWO = 6'h03;
    localparam logic [5:0] IDX_UART_STATUS = 6'h0E;
    localparam logic [5:0] IDX_TRANSMIT_HOLDING = 6'h10;
    localparam logic [5:0] IDX_RECEIVE_HOLDING = 6'h11;
    localparam logic [5:0] IDX_UART_CONTROL = 6'h12;
    // Status bit positions.
    localparam int ST_TIMEOUT_THREE = 7;
    localparam int ST_TIMEOUT_ONE = 5;
    localparam int ST_EARLY_ANSWER = 4;
    localparam int ST_PARITY_ERROR = 3;
    localparam int ST_OVERRUN = 2;
    localparam int ST_FRAMING_ERROR = 1;
    localparam int ST_BUFFER = 0;
    localparam logic [7:0] ST_IRQ_MASK = 8'hBE;
    // Second configuration register bit positions.
    localparam int C2_WAKE_IRQ_ENABLE = 7;
    localparam int C2_BUFFER_IRQ_DISABLE = 6;
    localparam int C2_SYNC_CARD_MODE = 3;
    localparam int C2_CONVENTION_MANUAL = 2;
    localparam int C2_DOUBLE_RATE_CLOCK = 1;
    localparam int C2_PRESCALER_SELECT = 0;
    // Control register bit positions.
    localparam int CT_TRANSMIT_MODE = 0;
    localparam int CT_PROTOCOL_T1 = 1;
    localparam int CT_LAST_CHAR_MARKER = 2;
    localparam int CT_SESSION_START = 3;
    localparam int CT_CONVENTION_SELECT = 4;
    localparam int CT_PEC_LO = 8;
    localparam int CT_WIDTH = 11;
    // Reset values: everything clears.
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [10:0] RESET_CONTROL = 11'h000;
    // Prescaler choices.
    localparam logic [5:0] PRESCALE_LONG = 6'h20;
    localparam logic [5:0] PRESCALE_SHORT = 6'h1F;
    // Character timing points, in quarter ETU after the start edge.
    localparam logic [5:0] QTR_FRAMING = 6'h29;
    localparam logic [5:0] QTR_RECEIVE = 6'h2A;
    localparam logic [5:0] QTR_TRANSMIT = 6'h2E;
    // Early answer windows, in card clock pulses.
    localparam logic [8:0] EA_IGNORE_CLOCKS = 9'h0C8;
    localparam logic [8:0] EA_LIMIT_CLOCKS = 9'h180;
    // Delay from a read or write to the clear it causes.
    localparam int CLEAR_DELAY = 2;
endpackage

// File: scu_status_etu.sv
// Smart-card UART status flags, interrupt request, ETU divider and AHB-Lite register slave.
`timescale 1ns/1ps
// Behaviour
// - Timeout-three flag sets when counter three or its chain reaches terminal count.
// - Timeout-one flag sets when timeout counter one reaches terminal count.
// - Reset low: early answer if first start bit falls between clocks 200 and 384.
// - Reset high: early answer if a start bit comes before clock 384.
// - Both early answer measurements restart on every card reset level change.
// - T=0 parity flag after programmed error or NAK count, at 10.5/11.5 ETU.
// - T=0 drops bad parity characters; T=1 stores them, counter idle.
// - Overrun flag at 10.5 ETU when a character arrives with receive register full.
// - Framing flag if I/O is low at 10.25 ETU; cleared by status read.
// - Status bit 0 is transmit-empty in transmission, receive-full in reception.
// - Transmit-empty sets at 11.5 ETU (T=0) or 10.5 (T=1); cleared by write or direction.
// - Receive-full sets whenever the FIFO becomes full in reception; cleared by read, or by entering reception if the FIFO was not full on entering transmission.
// - Interrupt request low while any error, early answer or timeout flag is set.
// - A status read clears the interrupting flags two clocks after the read.
// - Buffer flag also pulls the interrupt low unless buffer interrupts are disabled.
// - Buffer flag clears two clocks after holding access, or on conditional switch to reception.
// - With the last-character marker, no transmit-empty after the final character.
// - An 8-bit autoreload counter counts the divider down to one, reloading there, forming the ETU.
// - Prescaler is 32 when selected, else 31; ETU is prescaler times divider.
// - Double rate clock halves the ETU unless the card runs from the crystal.
// - Convention is detected on the first character unless manual convention is set.
// - Synchronous mode bypasses the UART, wiring bit 0 of holding registers to I/O.
module scu_status_etu (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic card_io_in,
    output logic card_io_out,
    output logic card_io_oe,
    input wire logic card_rst_level,
    input wire logic card_clk_from_xtal,
    input wire logic timeout_three_tc,
    input wire logic timeout_one_tc,
    input wire logic rx_parity_bad,
    input wire logic card_nak,
    input wire logic fifo_full,
    input wire logic [7:0] rx_data,
    input wire logic tr_clear_hw,
    output logic rx_store,
    output logic rx_read,
    output logic [7:0] tx_data,
    output logic tx_write,
    output logic etu_tick,
    output logic convention_detect_en,
    output logic convention_select,
    output logic last_char_marker,
    output logic protocol_t1,
    output logic transmit_mode,
    output logic uart_bypass,
    output logic wake_irq_enable,
    output logic uart_irq_n
);
    typedef struct packed {
        logic wr_pend;
        logic [5:0] wr_idx;
        logic [31:0] hrdata;
        logic [7:0] etu_divider;
        logic [7:0] uart_config_two;
        logic [10:0] ctrl;
        logic [7:0] status;
        logic [7:0] snap;
        logic [1:0] snap_pipe;
        logic [1:0] buf_pipe;
        logic [7:0] tx_data;
        logic tx_write;
        logic rx_read;
        logic rx_store;
        logic io_s1;
        logic io_s2;
        logic io_prev;
        logic card_ce;
        logic [5:0] presc_cnt;
        logic [7:0] div_cnt;
        logic etu_tick;
        logic char_active;
        logic [17:0] char_cnt;
        logic [8:0] ea_cnt;
        logic ea_seen;
        logic rst_prev;
        logic [2:0] pe_cnt;
        logic fifo_prev;
        logic fifo_at_tx;
    } scu_state_t;

    scu_state_t st;
    scu_state_t next_st;

    // Cycles of clk from the start edge to a timing point given in quarter ETU.
    function automatic logic [17:0] scu_point(input logic [15:0] etu, input logic [5:0] qtr);
        logic [21:0] prod;
        prod = 22'(etu) * 22'(qtr);
        return prod[19:2];
    endfunction

    logic [5:0] prescale;
    logic double_rate;
    logic [7:0] divider_eff;
    logic [15:0] etu_clks;
    logic [2:0] pec;
    logic io_fall;
    logic t1;
    logic tx_mode;
    logic at_framing;
    logic at_receive;
    logic at_transmit;
    logic addr_ok;
    logic pe_hit;

    // ETU length in clk cycles; the card clock is clk/2 unless double rate applies.
    always_comb begin
        prescale = st.uart_config_two[scu_pkg::C2_PRESCALER_SELECT]
            ? scu_pkg::PRESCALE_LONG : scu_pkg::PRESCALE_SHORT;
        double_rate = st.uart_config_two[scu_pkg::C2_DOUBLE_RATE_CLOCK]
            && !card_clk_from_xtal;
        // A zero divider would give a zero ETU, so it acts as one.
        divider_eff = (st.etu_divider == 8'h00) ? 8'h01 : st.etu_divider;
        etu_clks = (16'(prescale) * 16'(divider_eff)) << !double_rate; // Card clock is clk/2.
        pec = st.ctrl[scu_pkg::CT_PEC_LO +: 3];
        t1 = st.ctrl[scu_pkg::CT_PROTOCOL_T1];
        tx_mode = st.ctrl[scu_pkg::CT_TRANSMIT_MODE];
        io_fall = st.io_prev && !st.io_s2;
        at_framing = st.char_active && st.char_cnt == scu_point(etu_clks, scu_pkg::QTR_FRAMING);
        at_receive = st.char_active && st.char_cnt == scu_point(etu_clks, scu_pkg::QTR_RECEIVE);
        at_transmit = st.char_active && st.char_cnt == scu_point(etu_clks, scu_pkg::QTR_TRANSMIT);
        addr_ok = hsel && hready && htrans[1];
        pe_hit = (st.pe_cnt == pec);
    end

    // All next-state logic of the block.
    always_comb begin
        next_st = st;
        next_st.tx_write = 1'b0;
        next_st.rx_read = 1'b0;
        next_st.rx_store = 1'b0;
        next_st.etu_tick = 1'b0;
        next_st.wr_pend = 1'b0;
        next_st.snap_pipe = {st.snap_pipe[0], 1'b0};
        next_st.buf_pipe = {st.buf_pipe[0], 1'b0};

        // Pin synchroniser; the edge detector looks only at the second stage.
        next_st.io_s1 = card_io_in;
        next_st.io_s2 = st.io_s1;
        next_st.io_prev = st.io_s2;

        // Flags cleared by an earlier status read or holding access; events below may set them again.
        if (st.snap_pipe[1]) begin
            next_st.status = st.status & ~(st.snap & scu_pkg::ST_IRQ_MASK);
        end
        if (st.buf_pipe[1]) begin
            next_st.status[scu_pkg::ST_BUFFER] = 1'b0;
        end

        // Bus data phase of a write: the registers take hwdata at its end.
        if (st.wr_pend) begin
            unique case (st.wr_idx)
                scu_pkg::IDX_ETU_DIVIDER: next_st.etu_divider = hwdata[7:0];
                scu_pkg::IDX_UART_CONFIG_TWO: next_st.uart_config_two = hwdata[7:0];
                scu_pkg::IDX_UART_CONTROL: next_st.ctrl = hwdata[scu_pkg::CT_WIDTH-1:0];
                scu_pkg::IDX_TRANSMIT_HOLDING: begin
                    next_st.tx_data = hwdata[7:0];
                    next_st.tx_write = 1'b1;
                    next_st.buf_pipe[0] = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // Hardware end of transmission clears the direction bit.
        if (tr_clear_hw) begin
            next_st.ctrl[scu_pkg::CT_TRANSMIT_MODE] = 1'b0;
        end

        // Address phase: read data is fetched now so that it stands in the data phase.
        if (addr_ok) begin
            next_st.wr_pend = hwrite;
            next_st.wr_idx = haddr[7:2];
            next_st.hrdata = 32'h0000_0000;
            if (!hwrite) begin
                unique case (haddr[7:2])
                    scu_pkg::IDX_ETU_DIVIDER: next_st.hrdata[7:0] = st.etu_divider;
                    scu_pkg::IDX_UART_CONFIG_TWO: next_st.hrdata[7:0] = st.uart_config_two;
                    scu_pkg::IDX_UART_CONTROL:
                        next_st.hrdata[scu_pkg::CT_WIDTH-1:0] = st.ctrl;
                    scu_pkg::IDX_UART_STATUS: begin
                        next_st.hrdata[7:0] = st.status;
                        next_st.snap = st.status;
                        next_st.snap_pipe[0] = 1'b1;
                    end
                    scu_pkg::IDX_RECEIVE_HOLDING: begin
                        next_st.hrdata[7:0] = st.uart_config_two[scu_pkg::C2_SYNC_CARD_MODE]
                            ? {7'h00, st.io_s2} : rx_data;
                        next_st.rx_read = 1'b1;
                        next_st.buf_pipe[0] = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Card clock enable, prescaler and the autoreload divider.
        next_st.card_ce = double_rate ? 1'b1 : !st.card_ce;
        if (st.card_ce) begin
            if (st.presc_cnt >= prescale - 6'h01) begin
                next_st.presc_cnt = 6'h00;
                if (st.div_cnt <= 8'h01) begin // Reload at one: divider periods per ETU.
                    next_st.div_cnt = st.etu_divider;
                    next_st.etu_tick = st.etu_divider != 8'h00;
                end else begin
                    next_st.div_cnt = st.div_cnt - 8'h01;
                end
            end else begin
                next_st.presc_cnt = st.presc_cnt + 6'h01;
            end
        end

        // Character timer, started by a start edge on the card line.
        if (st.uart_config_two[scu_pkg::C2_SYNC_CARD_MODE]) begin
            next_st.char_active = 1'b0;
        end else if (st.char_active) begin
            next_st.char_cnt = st.char_cnt + 18'h00001;
            if (at_transmit) begin
                next_st.char_active = 1'b0;
            end
        end else if (io_fall) begin
            next_st.char_active = 1'b1;
            next_st.char_cnt = 18'h00001;
        end

        // Framing check at 10.25 ETU.
        if (at_framing && !st.io_s2) begin
            next_st.status[scu_pkg::ST_FRAMING_ERROR] = 1'b1;
        end

        // Reception point at 10.5 ETU.
        if (at_receive && !tx_mode) begin
            if (rx_parity_bad && !t1) begin
                // T=0: the character is dropped and counted.
                if (pe_hit) begin
                    next_st.status[scu_pkg::ST_PARITY_ERROR] = 1'b1;
                    next_st.pe_cnt = 3'h0;
                end else begin
                    next_st.pe_cnt = st.pe_cnt + 3'h1;
                end
            end else begin
                if (rx_parity_bad) begin
                    next_st.status[scu_pkg::ST_PARITY_ERROR] = 1'b1;
                end
                if (!t1) begin
                    next_st.pe_cnt = 3'h0;
                end
                if (fifo_full) begin
                    next_st.status[scu_pkg::ST_OVERRUN] = 1'b1;
                end else begin
                    next_st.rx_store = 1'b1;
                end
            end
        end

        // Transmission points: 10.5 ETU in T=1, 11.5 ETU in T=0.
        if (tx_mode && ((t1 && at_receive) || (!t1 && at_transmit))) begin
            if (!t1 && card_nak) begin
                if (pe_hit) begin
                    next_st.status[scu_pkg::ST_PARITY_ERROR] = 1'b1;
                    next_st.pe_cnt = 3'h0;
                end else begin
                    next_st.pe_cnt = st.pe_cnt + 3'h1;
                end
            end else if (!st.ctrl[scu_pkg::CT_LAST_CHAR_MARKER]) begin
                next_st.status[scu_pkg::ST_BUFFER] = 1'b1;
            end
        end

        // Receive-full: the FIFO filling in reception sets the shared bit.
        next_st.fifo_prev = fifo_full;
        if (!tx_mode && fifo_full && !st.fifo_prev) begin
            next_st.status[scu_pkg::ST_BUFFER] = 1'b1;
        end

        // Direction changes; leaving transmission clears transmit-empty unless the FIFO was full on entering transmission.
        if (next_st.ctrl[scu_pkg::CT_TRANSMIT_MODE] && !tx_mode) begin
            next_st.fifo_at_tx = fifo_full;
        end
        if (!next_st.ctrl[scu_pkg::CT_TRANSMIT_MODE] && tx_mode && !st.fifo_at_tx) begin
            next_st.status[scu_pkg::ST_BUFFER] = 1'b0;
        end

        // Early answer measurement in card clocks, restarted on each reset toggle.
        next_st.rst_prev = card_rst_level;
        if (card_rst_level != st.rst_prev) begin
            next_st.ea_cnt = 9'h000;
            next_st.ea_seen = 1'b0;
        end else begin
            if (st.card_ce && st.ea_cnt < scu_pkg::EA_LIMIT_CLOCKS) begin
                next_st.ea_cnt = st.ea_cnt + 9'h001;
            end
            if (io_fall && !st.ea_seen && st.ea_cnt < scu_pkg::EA_LIMIT_CLOCKS) begin
                if (card_rst_level) begin
                    next_st.ea_seen = 1'b1;
                    next_st.status[scu_pkg::ST_EARLY_ANSWER] = 1'b1;
                end else if (st.ea_cnt >= scu_pkg::EA_IGNORE_CLOCKS) begin
                    next_st.ea_seen = 1'b1;
                    next_st.status[scu_pkg::ST_EARLY_ANSWER] = 1'b1;
                end
            end
        end

        // Timeout counters live elsewhere; their terminal counts set sticky flags.
        if (timeout_three_tc) begin
            next_st.status[scu_pkg::ST_TIMEOUT_THREE] = 1'b1;
        end
        if (timeout_one_tc) begin
            next_st.status[scu_pkg::ST_TIMEOUT_ONE] = 1'b1;
        end
    end

    // One register stage holds the whole state.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.io_s1 <= 1'b1;
            st.io_s2 <= 1'b1;
            st.io_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // The slave never waits and never errors.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.hrdata;

    // Interrupt request; buffer flag participates unless masked.
    assign uart_irq_n = !(|(st.status & scu_pkg::ST_IRQ_MASK)
        || (st.status[scu_pkg::ST_BUFFER]
        && !st.uart_config_two[scu_pkg::C2_BUFFER_IRQ_DISABLE]));

    // Synchronous cards: bit 0 of the holding register drives the line open-drain.
    assign uart_bypass = st.uart_config_two[scu_pkg::C2_SYNC_CARD_MODE];
    assign card_io_out = 1'b0;
    assign card_io_oe = uart_bypass && !st.tx_data[0];

    // Convention detection runs during a session unless software sets it.
    assign convention_detect_en = !st.uart_config_two[scu_pkg::C2_CONVENTION_MANUAL]
        && st.ctrl[scu_pkg::CT_SESSION_START];
    assign convention_select = st.ctrl[scu_pkg::CT_CONVENTION_SELECT];
    assign last_char_marker = st.ctrl[scu_pkg::CT_LAST_CHAR_MARKER];
    assign protocol_t1 = st.ctrl[scu_pkg::CT_PROTOCOL_T1];
    assign transmit_mode = st.ctrl[scu_pkg::CT_TRANSMIT_MODE];
    assign wake_irq_enable = st.uart_config_two[scu_pkg::C2_WAKE_IRQ_ENABLE];
    assign rx_store = st.rx_store;
    assign rx_read = st.rx_read;
    assign tx_data = st.tx_data;
    assign tx_write = st.tx_write;
    assign etu_tick = st.etu_tick;
endmodule

// File: scu_card_model.sv
// Behavioural smart card that pulls the open-drain I/O line to send start bits.
`timescale 1ns/1ps
module scu_card_model (
    input wire logic clk,
    input wire logic card_io_oe,
    output logic card_io
);
    logic drive_low = 1'b0;

    // The line has a pull-up, so it reads high whenever neither party pulls it low.
    assign card_io = !(drive_low || card_io_oe);

    // Holds the line low for a number of clocks, then releases it to the pull-up.
    task automatic frame(input int low_clks);
        @(posedge clk);
        drive_low <= 1'b1;
        repeat (low_clks) @(posedge clk);
        drive_low <= 1'b0;
    endtask
endmodule

// File: scu_status_etu_chk.sv
// Checker for the card UART status block, bound to its top module.
`timescale 1ns/1ps
module scu_status_etu_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic timeout_three_tc,
    input wire logic timeout_one_tc,
    input wire logic rx_parity_bad,
    input wire logic fifo_full,
    input wire logic tr_clear_hw,
    input wire logic rx_store,
    input wire logic rx_read,
    input wire logic [7:0] tx_data,
    input wire logic tx_write,
    input wire logic protocol_t1,
    input wire logic transmit_mode,
    input wire logic uart_bypass,
    input wire logic card_io_oe,
    input wire logic uart_irq_n
);
    logic acc;
    logic rd_rx;
    logic wr_tx;

    // Accepted address phases aimed at the two holding registers.
    assign acc = hsel && hready && htrans[1];
    assign rd_rx = acc && !hwrite && haddr == {24'h0, scu_pkg::IDX_RECEIVE_HOLDING, 2'b00};
    assign wr_tx = acc && hwrite && haddr == {24'h0, scu_pkg::IDX_TRANSMIT_HOLDING, 2'b00};

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    to_three_irq_a: assert property (timeout_three_tc |=> !uart_irq_n)
        else $error("timeout three did not raise the interrupt");
    to_one_irq_a: assert property (timeout_one_tc |=> !uart_irq_n)
        else $error("timeout one did not raise the interrupt");
    rx_read_pulse_a: assert property (rx_read == $past(rd_rx))
        else $error("receive read pulse does not follow its address phase");
    tx_write_data_a: assert property (wr_tx |-> ##2 (tx_write && tx_data == $past(hwdata[7:0])))
        else $error("transmit write pulse or data wrong");
    sync_oe_idle_a: assert property (!uart_bypass && !$past(uart_bypass) |-> !card_io_oe)
        else $error("I/O driven outside synchronous mode");
    overrun_nostore_a: assert property (rx_store |-> !$past(fifo_full) ##1 !rx_store)
        else $error("character stored while receive register full");
    parity_drop_a: assert property (rx_store && !protocol_t1 |-> !$past(rx_parity_bad))
        else $error("bad parity character stored in T=0");
    dir_clear_a: assert property (tr_clear_hw |=> !transmit_mode)
        else $error("transmit mode not cleared by hardware");
endmodule

bind scu_status_etu scu_status_etu_chk scu_status_etu_chk_inst (.clk, .reset_n, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hwdata, .timeout_three_tc, .timeout_one_tc, .rx_parity_bad,
    .fifo_full, .tr_clear_hw, .rx_store, .rx_read, .tx_data, .tx_write, .protocol_t1,
    .transmit_mode, .uart_bypass, .card_io_oe, .uart_irq_n);

// File: scu_status_etu_tb.sv
// Self-checking testbench for the card UART status block.
`timescale 1ns/1ps
module scu_status_etu_tb;
    localparam logic [31:0] A_DIV = {24'h0, scu_pkg::IDX_ETU_DIVIDER, 2'b00};
    localparam logic [31:0] A_C2 = {24'h0, scu_pkg::IDX_UART_CONFIG_TWO, 2'b00};
    localparam logic [31:0] A_ST = {24'h0, scu_pkg::IDX_UART_STATUS, 2'b00};
    localparam logic [31:0] A_TX = {24'h0, scu_pkg::IDX_TRANSMIT_HOLDING, 2'b00};
    localparam logic [31:0] A_RX = {24'h0, scu_pkg::IDX_RECEIVE_HOLDING, 2'b00};
    localparam logic [31:0] A_CT = {24'h0, scu_pkg::IDX_UART_CONTROL, 2'b00};
    logic clk = 0, reset_n = 0, hsel = 0, hwrite = 0, card_rst_level = 0, card_clk_from_xtal = 0;
    logic timeout_three_tc = 0, timeout_one_tc = 0, rx_parity_bad = 0, fifo_full = 0;
    logic tr_clear_hw = 0, hreadyout, hresp, card_io_in, card_io_out, card_io_oe, rx_store;
    logic rx_read, tx_write, etu_tick, convention_detect_en, convention_select, last_char_marker;
    logic protocol_t1, transmit_mode, uart_bypass, wake_irq_enable, uart_irq_n;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] rx_data = 8'h5A, tx_data;
    int fails = 0, num_checks = 0, stores = 0;

    scu_status_etu scu_status_etu_inst (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .card_io_in, .card_io_out,
        .card_io_oe, .card_rst_level, .card_clk_from_xtal, .timeout_three_tc, .timeout_one_tc,
        .rx_parity_bad, .card_nak(1'b0), .fifo_full, .rx_data, .tr_clear_hw, .rx_store, .rx_read,
        .tx_data, .tx_write, .etu_tick, .convention_detect_en, .convention_select,
        .last_char_marker, .protocol_t1, .transmit_mode, .uart_bypass, .wake_irq_enable,
        .uart_irq_n);
    scu_card_model scu_card_model_inst (.clk, .card_io_oe, .card_io(card_io_in));

    // Clock at 100 MHz.
    always #5 clk = !clk;

    // Counts stored characters so dropped ones can be noticed.
    always @(posedge clk) if (rx_store === 1'b1) stores++;

    task automatic final_report;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Waits n edges, then lets that edge's updates settle.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One single AHB-Lite transfer; the master waits for hready at both phases.
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        #1;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, e);
    endtask

    // Card sends a start with the line low for low clocks; waits out the character.
    task automatic chr(input int low);
        scu_card_model_inst.frame(low);
        tick(760 - low);
    endtask

    // Measures clocks between two ETU ticks.
    task automatic etu(input int e);
        int n;
        repeat (2) begin
            do tick(1); while (etu_tick !== 1'b1);
        end
        n = 0;
        do begin
            tick(1);
            n++;
        end while (etu_tick !== 1'b1 && n < 400);
        chk(n, e);
    endtask

    // Bails out of a hang.
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        final_report;
    end

    initial begin
        tick(4);
        reset_n <= 1'b1;
        tick(1);
        rdc(A_DIV, 32'h0);
        rdc(A_C2, 32'h0);
        wr(A_ST, 32'hFF);
        rdc(A_ST, 32'h0);
        wr(32'h3C, 32'hFF);
        rdc(32'h3C, 32'h0);
        wr(A_DIV, 32'hA5);
        rdc(A_DIV, 32'hA5);
        wr(A_C2, 32'h41);
        rdc(A_C2, 32'h41);
        wr(A_DIV, 32'h1);
        wr(A_C2, 32'h1);
        // Each timeout sets its bit, pulls the request low, and a read clears it two edges on.
        for (int i = 0; i < 2; i++) begin
            if (i == 0) timeout_three_tc <= 1'b1;
            else timeout_one_tc <= 1'b1;
            tick(1);
            timeout_three_tc <= 1'b0;
            timeout_one_tc <= 1'b0;
            tick(1);
            chk(uart_irq_n, 1'b0);
            rdc(A_ST, (i == 0) ? 32'h80 : 32'h20);
            chk(uart_irq_n, 1'b0);
            tick(1);
            chk(uart_irq_n, 1'b1);
        end
        card_rst_level <= 1'b1;
        tick(100);
        chr(64);
        rdc(A_ST, 32'h10);
        card_rst_level <= 1'b0;
        tick(500);
        chr(64);
        rdc(A_ST, 32'h10);
        card_rst_level <= 1'b1;
        tick(900);
        chr(64);
        rdc(A_ST, 32'h0);
        chr(700);
        rdc(A_ST, 32'h02);
        fifo_full <= 1'b1;
        tick(2);
        chk(uart_irq_n, 1'b0);
        wr(A_C2, 32'h41);
        chk(uart_irq_n, 1'b1);
        chr(64);
        rdc(A_ST, 32'h05);
        rdc(A_RX, 32'h5A);
        tick(1);
        rdc(A_ST, 32'h0);
        fifo_full <= 1'b0;
        wr(A_C2, 32'h1);
        rx_parity_bad <= 1'b1;
        chr(64);
        rdc(A_ST, 32'h08);
        chk(stores, 32'd4);
        wr(A_CT, 32'h2);
        chr(64);
        chk(stores, 32'd5);
        rdc(A_ST, 32'h08);
        rx_parity_bad <= 1'b0;
        wr(A_CT, 32'h1);
        chk(transmit_mode, 1'b1);
        chr(64);
        rdc(A_ST, 32'h01);
        wr(A_TX, 32'h3C);
        tick(2);
        rdc(A_ST, 32'h0);
        wr(A_CT, 32'h5);
        chr(64);
        rdc(A_ST, 32'h0);
        tr_clear_hw <= 1'b1;
        tick(1);
        tr_clear_hw <= 1'b0;
        tick(1);
        chk(transmit_mode, 1'b0);
        wr(A_DIV, 32'h2);
        etu(128);
        wr(A_C2, 32'h0);
        etu(124);
        wr(A_C2, 32'h2);
        etu(62);
        card_clk_from_xtal <= 1'b1;
        etu(124);
        wr(A_C2, 32'h8);
        wr(A_TX, 32'h0);
        tick(2);
        chk(card_io_oe, 1'b1);
        rdc(A_RX, 32'h0);
        wr(A_TX, 32'h1);
        tick(2);
        chk(card_io_oe, 1'b0);
        rdc(A_RX, 32'h1);
        wr(A_CT, 32'h1C);
        chk(convention_detect_en, 1'b1);
        chk({last_char_marker, convention_select}, 2'h3);
        wr(A_C2, 32'h84);
        chk({convention_detect_en, wake_irq_enable}, 2'h1);
        final_report;
    end
endmodule
